/* File: logic/srcmatch_pkg.sv */
`default_nettype none
package srcmatch_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          ADDR_W        = 11;
  localparam int          TABLE_BYTES   = 96;
  localparam int          SLOTS         = 12;
  localparam int          ENTRIES       = 24;

  // ==========================================================================
  // Register map (byte addresses on the register port)
  localparam logic [10:0] TABLE_BASE    = 11'h380;
  localparam logic [10:0] TABLE_LAST    = 11'h3df;
  localparam logic [10:0] RESMASK0_ADDR = 11'h3e0;
  localparam logic [10:0] RESMASK1_ADDR = 11'h3e1;
  localparam logic [10:0] RESMASK2_ADDR = 11'h3e2;
  localparam logic [10:0] RESINDEX_ADDR = 11'h3e3;
  localparam logic [10:0] EXTPEND0_ADDR = 11'h3e4;
  localparam logic [10:0] EXTPEND2_ADDR = 11'h3e6;
  localparam logic [10:0] SHRPEND0_ADDR = 11'h3e7;
  localparam logic [10:0] SHRPEND2_ADDR = 11'h3e9;
  localparam logic [10:0] CTRL_ADDR     = 11'h400;
  localparam logic [10:0] IRQ_STAT_ADDR = 11'h401;
  localparam logic [10:0] IRQ_MASK_ADDR = 11'h402;

  // ==========================================================================
  // Field positions and reset values
  localparam int          IDX_EXT_BIT   = 5;
  localparam int          IDX_PEND_BIT  = 6;
  localparam logic [7:0]  IDX_NONE      = 8'h3f;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_PEND_BIT = 1;
  localparam logic [7:0]  CTRL_RESET    = 8'h01;
  localparam int          IRQ_DONE_BIT  = 0;
  localparam int          IRQ_HIT_BIT   = 1;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam logic [23:0] MASK24_RESET  = 24'h000000;

  // ==========================================================================
  // Source address of a received frame, from the receive filter
  typedef struct packed {
    logic        is_ext;   // 1: extended source address
    logic [15:0] pan_id;
    logic [15:0] short_addr;
    logic [63:0] ext_addr;
  } frame_src_t;

endpackage
`default_nettype wire

/* File: logic/srcmatch_slot_cmp.sv */
`timescale 1ns/10ps
`default_nettype none
module srcmatch_slot_cmp
  import srcmatch_pkg::*;
(
  // One 8-byte slot, byte 0 in bits 7:0
  input  wire logic [63:0] slot,
  // Frame source address
  input  wire frame_src_t  src,
  // Mask bits 2k and 2k+1
  output logic [1:0]       hit
);

  // Slot is two short entries or one extended entry, little endian
  always_comb begin
    if (src.is_ext) begin
      hit = (slot == src.ext_addr) ? 2'h3 : 2'h0;
    end else begin
      hit[0] = (slot[15:0] == src.pan_id) && (slot[31:16] == src.short_addr);
      hit[1] = (slot[47:32] == src.pan_id) && (slot[63:48] == src.short_addr);
    end
  end

endmodule
`default_nettype wire

/* File: logic/srcmatch_lowest_bit.sv */
`timescale 1ns/10ps
`default_nettype none
module srcmatch_lowest_bit #(
  parameter int WIDTH = 24
) (
  // Mask to search
  input  wire logic [WIDTH-1:0] mask,
  // Position of lowest set bit and presence
  output logic [4:0]            pos,
  output logic                  found
);

  // Scan from the top so the lowest set bit wins
  always_comb begin
    pos   = 5'h00;
    found = 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        pos   = 5'(i);
        found = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: logic/source_address_match_table.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module source_address_match_table
  import srcmatch_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [10:0] BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  input  wire logic        BUS_WR,
  input  wire logic        BUS_RD,
  output logic [7:0]       BUS_RDATA,
  // Receive frame filter
  input  wire logic        FRAME_START,
  input  wire logic        SRC_VALID,
  input  wire frame_src_t  SRC_INFO,
  // Match results
  output logic             MATCH_DONE,
  output logic             MATCH_HIT,
  output logic [7:0]       MATCH_INDEX,
  output logic [23:0]      MATCH_MASK,
  // Interrupt
  output logic             IRQ
);

  // ==========================================================================
  // Storage
  logic [7:0]  table_r [TABLE_BYTES];
  logic [23:0] brief_entry_pending_mask_r;
  logic [23:0] long_entry_pending_mask_r;
  logic [7:0]  ctrl_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_stat_nxt;
  logic [1:0]  irq_mask_r;
  logic [23:0] match_result_mask_r;
  logic [7:0]  match_result_index_r;
  logic        match_hit_r;
  logic        done_r;
  logic        irq_r;
  logic [7:0]  rdata_r;

  // ==========================================================================
  // Address decode helpers
  logic        in_table;
  logic [6:0]  table_idx;
  logic [1:0]  ext_lane;
  logic [1:0]  shr_lane;

  assign in_table  = (BUS_ADDR >= TABLE_BASE) && (BUS_ADDR <= TABLE_LAST);
  assign table_idx = 7'(BUS_ADDR - TABLE_BASE);
  assign ext_lane  = 2'(BUS_ADDR - EXTPEND0_ADDR);
  assign shr_lane  = 2'(BUS_ADDR - SHRPEND0_ADDR);

  // ==========================================================================
  // Comparison against every slot
  logic [23:0] hit_mask;
  logic [4:0]  low_pos;
  logic        low_found;
  logic        pend_bit;
  logic        auto_pend;
  logic [7:0]  index_nxt;

  genvar k;
  genvar j;
  generate
    for (k = 0; k < SLOTS; k++) begin : g_slot
      logic [63:0] slot_bytes;
      // Gather slot k, byte 8k lowest
      for (j = 0; j < 8; j++) begin : g_byte
        assign slot_bytes[j*8 +: 8] = table_r[k*8 + j];
      end
      // Short pair or extended compare; extended sets both bits
      srcmatch_slot_cmp u_cmp (
        .slot (slot_bytes),
        .src  (SRC_INFO),
        .hit  (hit_mask[2*k +: 2])
      );
    end
  endgenerate

  // Lowest matching entry
  srcmatch_lowest_bit #(
    .WIDTH (ENTRIES)
  ) u_low (
    .mask  (hit_mask),
    .pos   (low_pos),
    .found (low_found)
  );

  // Pending enable of the matched entry; extended entry k uses bit 2k
  assign pend_bit  = SRC_INFO.is_ext ? long_entry_pending_mask_r[low_pos]
                                     : brief_entry_pending_mask_r[low_pos];
  // Only table state decides; no force-pending or ack strobes enter here
  assign auto_pend = low_found && ctrl_r[CTRL_PEND_BIT] && pend_bit;

  // Index byte: position, extended flag, pending flag
  always_comb begin
    if (low_found) begin
      index_nxt               = {3'h0, low_pos};
      index_nxt[IDX_EXT_BIT]  = SRC_INFO.is_ext;
      index_nxt[IDX_PEND_BIT] = auto_pend;
    end else begin
      index_nxt = IDX_NONE;
    end
  end

  // ==========================================================================
  // Match results: cleared at frame start, loaded on accepted source address, which wins if both come in one cycle
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      match_result_mask_r  <= MASK24_RESET;
      match_result_index_r <= IDX_NONE;
      match_hit_r          <= 1'b0;
    end else if (SRC_VALID && ctrl_r[CTRL_EN_BIT]) begin
      match_result_mask_r  <= hit_mask;
      match_result_index_r <= index_nxt;
      match_hit_r          <= low_found;
    end else if (FRAME_START) begin
      match_result_mask_r  <= MASK24_RESET;
      match_result_index_r <= IDX_NONE;
      match_hit_r          <= 1'b0;
    end
  end

  // Completion pulse
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      done_r <= 1'b0;
    end else begin
      done_r <= SRC_VALID && ctrl_r[CTRL_EN_BIT];
    end
  end

  // ==========================================================================
  // Table writes from software
  // Table is not reset; software fills it before matching is used
  always_ff @(posedge REF_CLK) begin
    if (BUS_WR && in_table) begin
      table_r[table_idx] <= BUS_WDATA;
    end
  end

  // Pending enable masks, three bytes each, low byte lowest
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      long_entry_pending_mask_r  <= MASK24_RESET;
      brief_entry_pending_mask_r <= MASK24_RESET;
    end else if (BUS_WR) begin
      if (BUS_ADDR >= EXTPEND0_ADDR && BUS_ADDR <= EXTPEND2_ADDR) begin
        long_entry_pending_mask_r[ext_lane*8 +: 8] <= BUS_WDATA;
      end else if (BUS_ADDR >= SHRPEND0_ADDR && BUS_ADDR <= SHRPEND2_ADDR) begin
        brief_entry_pending_mask_r[shr_lane*8 +: 8] <= BUS_WDATA;
      end
    end
  end

  // Control and interrupt mask
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_r     <= CTRL_RESET;
      irq_mask_r <= IRQ_RESET;
    end else if (BUS_WR) begin
      if (BUS_ADDR == CTRL_ADDR) begin
        ctrl_r <= BUS_WDATA;
      end else if (BUS_ADDR == IRQ_MASK_ADDR) begin
        irq_mask_r <= BUS_WDATA[1:0];
      end
    end
  end

  // ==========================================================================
  // Interrupt status: write one to clear, a new event wins over the clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (BUS_WR && BUS_ADDR == IRQ_STAT_ADDR) begin
      irq_stat_nxt = irq_stat_r & ~BUS_WDATA[1:0];
    end
    if (done_r) begin
      irq_stat_nxt[IRQ_DONE_BIT] = 1'b1;
    end
    if (done_r && match_result_index_r != IDX_NONE) begin
      irq_stat_nxt[IRQ_HIT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      irq_stat_r <= IRQ_RESET;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ==========================================================================
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || !BUS_RD) begin
      rdata_r <= 8'h00;
    end else if (in_table) begin
      rdata_r <= table_r[table_idx];
    end else if (BUS_ADDR == RESMASK0_ADDR) begin
      rdata_r <= match_result_mask_r[7:0];
    end else if (BUS_ADDR == RESMASK1_ADDR) begin
      rdata_r <= match_result_mask_r[15:8];
    end else if (BUS_ADDR == RESMASK2_ADDR) begin
      rdata_r <= match_result_mask_r[23:16];
    end else if (BUS_ADDR == RESINDEX_ADDR) begin
      rdata_r <= match_result_index_r;
    end else if (BUS_ADDR >= EXTPEND0_ADDR && BUS_ADDR <= EXTPEND2_ADDR) begin
      rdata_r <= long_entry_pending_mask_r[ext_lane*8 +: 8];
    end else if (BUS_ADDR >= SHRPEND0_ADDR && BUS_ADDR <= SHRPEND2_ADDR) begin
      rdata_r <= brief_entry_pending_mask_r[shr_lane*8 +: 8];
    end else if (BUS_ADDR == CTRL_ADDR) begin
      rdata_r <= ctrl_r;
    end else if (BUS_ADDR == IRQ_STAT_ADDR) begin
      rdata_r <= {6'h00, irq_stat_r};
    end else if (BUS_ADDR == IRQ_MASK_ADDR) begin
      rdata_r <= {6'h00, irq_mask_r};
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ==========================================================================
  // Outputs
  assign BUS_RDATA   = rdata_r;
  assign MATCH_DONE  = done_r;
  assign MATCH_HIT   = match_hit_r;
  assign MATCH_INDEX = match_result_index_r;
  assign MATCH_MASK  = match_result_mask_r;
  assign IRQ         = irq_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Match result checks: mask, index, pending, completion and frame clear

  idx_ext_flag_a: assert property (
    SRC_VALID && ctrl_r[CTRL_EN_BIT] && low_found
    |=> MATCH_INDEX[IDX_EXT_BIT] == $past(SRC_INFO.is_ext))
    else $error("extended flag of index wrong");

  idx_pend_flag_a: assert property (
    SRC_VALID && ctrl_r[CTRL_EN_BIT] && low_found && !ctrl_r[CTRL_PEND_BIT]
    |=> !MATCH_INDEX[IDX_PEND_BIT])
    else $error("pending flag set with auto pending off");

  pend_entry_gate_a: assert property (
    SRC_VALID && ctrl_r[CTRL_EN_BIT] && low_found && ctrl_r[CTRL_PEND_BIT] && SRC_INFO.is_ext
    |=> MATCH_INDEX[IDX_PEND_BIT] == $past(long_entry_pending_mask_r[low_pos]))
    else $error("extended pending enable not honoured");

  mask_load_a: assert property (
    SRC_VALID && ctrl_r[CTRL_EN_BIT] |=> MATCH_DONE && MATCH_MASK == $past(hit_mask))
    else $error("result mask not loaded");

  ext_pair_bits_a: assert property (
    MATCH_DONE && MATCH_INDEX[IDX_EXT_BIT] && MATCH_HIT
    |-> MATCH_MASK[{MATCH_INDEX[4:1], 1'b0}] && MATCH_MASK[{MATCH_INDEX[4:1], 1'b1}])
    else $error("extended match did not set both bits");

  index_none_a: assert property (
    MATCH_DONE |-> (MATCH_MASK == 24'h000000) == (MATCH_INDEX == IDX_NONE))
    else $error("index disagrees with empty mask");

  index_lowest_a: assert property (
    MATCH_DONE && MATCH_HIT
    |-> MATCH_MASK[MATCH_INDEX[4:0]] && (MATCH_MASK & ((24'h000001 << MATCH_INDEX[4:0]) - 24'h000001)) == 24'h0)
    else $error("index is not the lowest set bit");

  frame_clear_a: assert property (
    FRAME_START && !SRC_VALID |=> MATCH_MASK == 24'h000000 && MATCH_INDEX == IDX_NONE)
    else $error("stale result after frame start");

  short_pend_gate_a: assert property (
    SRC_VALID && ctrl_r[CTRL_EN_BIT] && low_found && ctrl_r[CTRL_PEND_BIT] && !SRC_INFO.is_ext
    |=> MATCH_INDEX[IDX_PEND_BIT] == $past(brief_entry_pending_mask_r[low_pos]))
    else $error("short pending enable not honoured");

  pend_needs_hit_a: assert property (
    MATCH_INDEX[IDX_PEND_BIT] |-> MATCH_HIT && !MATCH_INDEX[7])
    else $error("pending flag without a match");

  hit_flag_a: assert property (
    MATCH_HIT == (MATCH_INDEX != IDX_NONE))
    else $error("hit flag disagrees with index");

  refused_hold_a: assert property (
    SRC_VALID && !ctrl_r[CTRL_EN_BIT] && !FRAME_START
    |=> !MATCH_DONE && $stable(MATCH_MASK) && $stable(MATCH_INDEX))
    else $error("refused source address changed results");

  done_pulse_a: assert property (
    MATCH_DONE |-> $past(SRC_VALID) && $past(ctrl_r[CTRL_EN_BIT]))
    else $error("completion without accepted source address");

  // ==========================================================================
  // Bus and status checks
  mask_read_only_a: assert property (
    BUS_WR && BUS_ADDR >= RESMASK0_ADDR && BUS_ADDR <= RESINDEX_ADDR && !SRC_VALID && !FRAME_START
    |=> $stable(MATCH_MASK) && $stable(MATCH_INDEX))
    else $error("result registers took a bus write");

  rdata_idle_a: assert property (
    !BUS_RD |=> BUS_RDATA == 8'h00)
    else $error("read data outside the read cycle");

  table_write_a: assert property (
    BUS_WR && in_table |=> table_r[$past(table_idx)] == $past(BUS_WDATA))
    else $error("table byte not written");

  ext_pend_write_a: assert property (
    BUS_WR && BUS_ADDR == EXTPEND0_ADDR + 11'h001 |=> long_entry_pending_mask_r[15:8] == $past(BUS_WDATA))
    else $error("extended pending mask not written");

  short_pend_write_a: assert property (
    BUS_WR && BUS_ADDR == SHRPEND0_ADDR |=> brief_entry_pending_mask_r[7:0] == $past(BUS_WDATA))
    else $error("short pending mask not written");

  set_wins_a: assert property (
    done_r |=> irq_stat_r[IRQ_DONE_BIT] && (irq_stat_r[IRQ_HIT_BIT] || !$past(match_hit_r)))
    else $error("status event lost against a clear");

  irq_level_a: assert property (
    |(irq_stat_r & irq_mask_r) && $stable(irq_mask_r) |-> IRQ)
    else $error("interrupt low with unmasked status");

endmodule
`default_nettype wire

/* File: verification/frame_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Receive frame filter model
module frame_src_model
  import srcmatch_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Frame side
  output logic       frame_start,
  output logic       src_valid,
  output frame_src_t src_info
);
  // Idle at time zero
  initial begin
    frame_start = 1'b0;
    src_valid   = 1'b0;
    src_info    = '0;
  end
  // New frame: a one-cycle start pulse, given before the address by the bench frame task
  task automatic start();
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
  endtask
  // Address valid for one cycle, then scrambled so stale data never looks valid
  task automatic give(input frame_src_t s);
    @(posedge clk);
    src_valid <= 1'b1;
    src_info  <= s;
    @(posedge clk);
    src_valid <= 1'b0;
    src_info  <= ~s;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bench for the source match table
module tb_top
  import srcmatch_pkg::*;
;
  logic        ref_clk;
  logic        rst_n;
  logic [10:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        frame_start;
  logic        src_valid;
  frame_src_t  src_info;
  logic        match_done;
  logic        match_hit;
  logic [7:0]  match_index;
  logic [23:0] match_mask;
  logic        irq;
  int          fails;
  int          tests_run;
  int          cycles = 0;

  source_address_match_table u_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .FRAME_START(frame_start),
    .SRC_VALID(src_valid), .SRC_INFO(src_info), .MATCH_DONE(match_done), .MATCH_HIT(match_hit),
    .MATCH_INDEX(match_index), .MATCH_MASK(match_mask), .IRQ(irq));
  frame_src_model u_src (.clk(ref_clk), .frame_start(frame_start), .src_valid(src_valid),
    .src_info(src_info));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Bus, compare and frame helpers
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic wr16(input logic [10:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 11'h001, d[15:8]);
  endtask
  task automatic wr64(input logic [10:0] a, input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      wr(a + 11'(i), d[8*i+:8]);
    end
  endtask
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk24({16'h0000, got}, {16'h0000, exp});
  endtask
  task automatic rdchk(input logic [10:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk8(bus_rdata, exp);
  endtask
  task automatic frame(input frame_src_t s);
    u_src.start();
    #1;
    chk24(match_mask, 24'h000000);
    chk8(match_index, IDX_NONE);
    chk8({7'h00, match_hit}, 8'h00);
    u_src.give(s);
    #1;
    chk8({7'h00, match_done}, 8'h01);
  endtask
  function automatic frame_src_t sh(input logic [15:0] pan, input logic [15:0] sa);
    return '{1'b0, pan, sa, 64'h0};
  endfunction
  function automatic frame_src_t ex(input logic [63:0] a);
    return '{1'b1, 16'h0000, 16'h0000, a};
  endfunction
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    rst_n     = 1'b0;
    bus_addr  = 11'h000;
    bus_wdata = 8'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    fails     = 0;
    tests_run = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset values and unmapped read
    rdchk(RESMASK0_ADDR, 8'h00);
    rdchk(RESMASK2_ADDR, 8'h00);
    rdchk(RESINDEX_ADDR, IDX_NONE);
    rdchk(CTRL_ADDR, CTRL_RESET);
    rdchk(11'h500, 8'h00);
    $display("test reset done");
    // Table: short entries 3 and 7 equal, extended entry 5
    for (int i = 0; i < TABLE_BYTES; i++) begin
      wr(TABLE_BASE + 11'(i), 8'hff);
    end
    wr16(TABLE_BASE + 11'h00c, 16'hbeef);
    wr16(TABLE_BASE + 11'h00e, 16'h1234);
    wr16(TABLE_BASE + 11'h01c, 16'hbeef);
    wr16(TABLE_BASE + 11'h01e, 16'h1234);
    wr64(TABLE_BASE + 11'h028, 64'h0011223344556677);
    rdchk(TABLE_BASE + 11'h00c, 8'hef);
    frame(sh(16'hbeef, 16'h1234));
    chk24(match_mask, 24'h000088);
    chk8(match_index, 8'h03);
    chk8({7'h00, match_hit}, 8'h01);
    wr(RESMASK0_ADDR, 8'h55);
    rdchk(RESMASK0_ADDR, 8'h88);
    rdchk(RESMASK1_ADDR, 8'h00);
    rdchk(RESINDEX_ADDR, 8'h03);
    frame(ex(64'h0011223344556677));
    chk24(match_mask, 24'h000c00);
    chk8(match_index, 8'h2a);
    rdchk(RESMASK1_ADDR, 8'h0c);
    frame(sh(16'hbeef, 16'h1235));
    chk24(match_mask, 24'h000000);
    chk8(match_index, IDX_NONE);
    chk8({7'h00, match_hit}, 8'h00);
    $display("test match done");
    // Automatic pending qualification
    wr(CTRL_ADDR, 8'h03);
    wr(EXTPEND0_ADDR + 11'h001, 8'h04);
    frame(ex(64'h0011223344556677));
    chk8(match_index, 8'h6a);
    wr(EXTPEND0_ADDR + 11'h001, 8'h08);
    frame(ex(64'h0011223344556677));
    chk8(match_index, 8'h2a);
    wr(SHRPEND0_ADDR, 8'h08);
    frame(sh(16'hbeef, 16'h1234));
    chk8(match_index, 8'h43);
    wr(SHRPEND0_ADDR, 8'h80);
    frame(sh(16'hbeef, 16'h1234));
    chk8(match_index, 8'h03);
    wr(SHRPEND0_ADDR, 8'h08);
    wr(CTRL_ADDR, 8'h01);
    frame(sh(16'hbeef, 16'h1234));
    chk8(match_index, 8'h03);
    $display("test pending done");
    // Interrupt raise, clear and mask
    wr(IRQ_STAT_ADDR, 8'h03);
    wr(IRQ_MASK_ADDR, 8'h02);
    frame(sh(16'hbeef, 16'h1234));
    chk8({7'h00, irq}, 8'h00);
    @(posedge ref_clk);
    #1;
    chk8({7'h00, irq}, 8'h01);
    rdchk(IRQ_STAT_ADDR, 8'h03);
    wr(IRQ_STAT_ADDR, 8'h03);
    #1;
    chk8({7'h00, irq}, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h00);
    frame(sh(16'hbeef, 16'h1234));
    repeat (2) @(posedge ref_clk);
    #1;
    chk8({7'h00, irq}, 8'h00);
    // Matching disabled: no completion
    wr(CTRL_ADDR, 8'h00);
    u_src.give(sh(16'hbeef, 16'h1234));
    #1;
    chk8({7'h00, match_done}, 8'h00);
    chk24(match_mask, 24'h000088);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
